// ==== pkg/dpsp_consts.vh ====
// Constants for the process-data status packer
`ifndef DPSP_CONSTS_VH
`define DPSP_CONSTS_VH
`define DPSP_TEL_STD1      10'h001
`define DPSP_TEL_STD352    10'h160
`define DPSP_TEL_STD20     10'h014
`define DPSP_BIT_FAULT     3
`define DPSP_BIT_LIMIT     11
`define DPSP_BIT_BRAKE     12
`define DPSP_BIT_RSVD13    13
`define DPSP_BIT_FWD       14
`define DPSP_BIT_CDS       15
`define DPSP_FULL_SCALE    16'h4000
`define DPSP_SAT_POS       16'h7FFF
`define DPSP_SAT_NEG       16'h8001
`define DPSP_SCALE_SHIFT   14
`define DPSP_NUM_WORDS     8
`define DPSP_NUM_TAPS      4
`define DPSP_FC_DATA       4'h0
`define DPSP_FC_BCAST      4'h1
`define DPSP_RST_WORD      16'h0000
`endif

// ==== hw/dpsp_scale.v ====
// Signed actual-value scaler with saturation
`timescale 1ns/10ps
`include "dpsp_consts.vh"
module dpsp_scale (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire signed [31:0] value_i,
  input  wire        [31:0] ref_i,
  input  wire               unsigned_i,
  output reg         [15:0] word_o
);
  wire signed [47:0] num;
  wire        [31:0] refs;
  wire signed [47:0] q;
  reg         [15:0] word_nxt;
  assign num  = {{16{value_i[31]}}, value_i} <<< `DPSP_SCALE_SHIFT;
  // Zero reference would divide by zero; treat as one
  assign refs = (ref_i == 32'h0000_0000) ? 32'h0000_0001 : ref_i;
  assign q    = num / $signed({16'h0000, refs});
  always @* begin
    if (q > $signed(48'h0000_0000_7FFF))
      word_nxt = `DPSP_SAT_POS;
    else if (unsigned_i && q < $signed(48'h0000_0000_0000))
      word_nxt = 16'h0000;
    else if (q < -$signed(48'h0000_0000_7FFF))
      word_nxt = `DPSP_SAT_NEG;
    else
      word_nxt = q[15:0];
  end
  always @(posedge clk_i) begin
    if (rst_i)
      word_o <= `DPSP_RST_WORD;
    else
      word_o <= word_nxt;
  end
endmodule // dpsp_scale

// ==== hw/dpsp_tap_merge.v ====
// Subscriber tap table merging publisher words into setpoints
`timescale 1ns/10ps
`include "dpsp_consts.vh"
module dpsp_tap_merge (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         subscriber_i,
  input  wire [127:0] master_sp_i,
  input  wire         master_sp_vld_i,
  input  wire [127:0] bcast_data_i,
  input  wire [6:0]   bcast_src_i,
  input  wire         bcast_vld_i,
  input  wire [27:0]  tap_src_i,
  input  wire [11:0]  tap_from_i,
  input  wire [11:0]  tap_to_i,
  input  wire [3:0]   tap_en_i,
  output reg  [127:0] setpoint_o
);
  reg [127:0] sp_nxt;
  integer     t;
  function [15:0] word_at;
    input [127:0] d;
    input [2:0]   i;
    begin
      word_at = d[i*16 +: 16];
    end
  endfunction
  always @* begin
    sp_nxt = setpoint_o;
    if (master_sp_vld_i)
      sp_nxt = master_sp_i;
    if (subscriber_i && bcast_vld_i) begin
      for (t = 0; t < `DPSP_NUM_TAPS; t = t + 1) begin
        if (tap_en_i[t] && tap_src_i[t*7 +: 7] == bcast_src_i)
          sp_nxt[tap_to_i[t*3 +: 3]*16 +: 16] = word_at(bcast_data_i, tap_from_i[t*3 +: 3]);
      end
    end
  end
  always @(posedge clk_i) begin
    if (rst_i)
      setpoint_o <= 128'h0;
    else
      setpoint_o <= sp_nxt;
  end
endmodule // dpsp_tap_merge

// ==== hw/dpsp_packer.v ====
// Process-data status packer top
//
// Behaviour
// - bit 11 high while limit not reached, low outside sel 1, 352, 20
// - bit 12 brake released, reserved sel 20
// - bit 14 high when speed nonnegative
// - bit 15 data set bit sel 20, 13 reserved
// - speed word 16 bit, bit15 sign
// - speed 4000 hex equals reference
// - current 4000 hex equals reference
// - torque signed, 4000 hex reference
// - power signed, 4000 hex reference
// - alarm code words as plain numbers
// - fault code oldest active, plain number
// - publisher answers broadcast on broadcast code
// - subscriber merges broadcast setpoints
// - links name source, inputs, destinations
// - standard slave uses master setpoints only
// - subscriber map taken from start-up telegrams
// - bit 3 high while fault held
`timescale 1ns/10ps
`include "dpsp_consts.vh"
module dpsp_packer (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [9:0]   telegram_structure_select_i,
  input  wire         limit_reached_i,
  input  wire         limit_reached_alt_i,
  input  wire         brake_released_i,
  input  wire         cds_sel0_i,
  input  wire         fault_active_i,
  input  wire signed [31:0] speed_i,
  input  wire signed [31:0] current_i,
  input  wire signed [31:0] torque_i,
  input  wire signed [31:0] power_i,
  input  wire [31:0]  speed_reference_i,
  input  wire [31:0]  current_reference_i,
  input  wire [31:0]  torque_reference_i,
  input  wire [31:0]  power_reference_i,
  input  wire [15:0]  alarm_current_i,
  input  wire [15:0]  alarm_last_i,
  input  wire [15:0]  fault_oldest_i,
  input  wire         poll_i,
  input  wire [3:0]   poll_fc_i,
  input  wire [127:0] master_sp_i,
  input  wire         cfg_load_i,
  input  wire         cfg_subscriber_i,
  input  wire [27:0]  cfg_tap_src_i,
  input  wire [11:0]  cfg_tap_from_i,
  input  wire [11:0]  cfg_tap_to_i,
  input  wire [3:0]   cfg_tap_en_i,
  input  wire [127:0] bcast_data_i,
  input  wire [6:0]   bcast_src_i,
  input  wire         bcast_vld_i,
  output reg  [15:0]  status_word_o,
  output wire [15:0]  speed_actual_word_o,
  output wire [15:0]  current_actual_word_o,
  output wire [15:0]  torque_actual_word_o,
  output wire [15:0]  power_actual_word_o,
  output reg  [15:0]  alarm_code_cur_o,
  output reg  [15:0]  alarm_code_last_o,
  output reg  [15:0]  fault_code_o,
  output reg          resp_vld_o,
  output reg          resp_bcast_o,
  output reg  [63:0]  resp_data_o,
  output wire [127:0] setpoint_o,
  output wire         subscriber_o
);
  // ****************************************
  // Status word
  // ****************************************
  reg  [15:0] status_nxt;
  reg         subscr_r;
  wire [27:0] tap_src_w;
  wire [11:0] tap_from_w;
  wire [11:0] tap_to_w;
  wire [3:0]  tap_en_w;
  wire        sel_std;
  wire        sel_20;
  genvar      g;

  // Telegrams 1 and 352 share one upper bit map
  function sel_is_std;
    input [9:0] sel;
    begin
      sel_is_std = (sel == `DPSP_TEL_STD1) || (sel == `DPSP_TEL_STD352);
    end
  endfunction

  function sel_is_alt;
    input [9:0] sel;
    begin
      sel_is_alt = (sel == `DPSP_TEL_STD20);
    end
  endfunction

  // Unknown codes answer as a plain exchange
  function fc_is_bcast;
    input [3:0] fc;
    begin
      fc_is_bcast = (fc == `DPSP_FC_BCAST);
    end
  endfunction

  // Telegram 20 takes the limit flag from its own source
  function limit_free;
    input std;
    input alt;
    input lim;
    input lim_alt;
    begin
      if (std)
        limit_free = ~lim;
      else if (alt)
        limit_free = ~lim_alt;
      else
        limit_free = 1'b0;
    end
  endfunction

  // Status word rides in the lowest slot
  function [63:0] pack_resp;
    input [15:0] w0;
    input [15:0] w1;
    input [15:0] w2;
    input [15:0] w3;
    begin
      pack_resp = {w3, w2, w1, w0};
    end
  endfunction

  assign sel_std = sel_is_std(telegram_structure_select_i);
  assign sel_20  = sel_is_alt(telegram_structure_select_i);
  always @* begin
    status_nxt = 16'h0000;
    status_nxt[`DPSP_BIT_FAULT] = fault_active_i;
    status_nxt[`DPSP_BIT_LIMIT] = limit_free(sel_std, sel_20, limit_reached_i,
                                             limit_reached_alt_i);
    if (sel_std)
      status_nxt[`DPSP_BIT_BRAKE] = brake_released_i;
    status_nxt[`DPSP_BIT_FWD] = ~speed_i[31];
    if (sel_20)
      status_nxt[`DPSP_BIT_CDS] = cds_sel0_i;
  end
  always @(posedge clk_i) begin
    if (rst_i)
      status_word_o <= `DPSP_RST_WORD;
    else
      status_word_o <= status_nxt;
  end

  // ****************************************
  // Alarm and fault codes
  // ****************************************
  // Numbers pass through unchanged; the host decodes them
  always @(posedge clk_i) begin
    if (rst_i) begin
      alarm_code_cur_o  <= `DPSP_RST_WORD;
      alarm_code_last_o <= `DPSP_RST_WORD;
      fault_code_o      <= `DPSP_RST_WORD;
    end else begin
      alarm_code_cur_o  <= alarm_current_i;
      alarm_code_last_o <= alarm_last_i;
      fault_code_o      <= fault_oldest_i;
    end
  end

  // ****************************************
  // Actual values
  // ****************************************
  // speed scaling
  dpsp_scale u_speed (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .value_i    (speed_i),
    .ref_i      (speed_reference_i),
    .unsigned_i (1'b0),
    .word_o     (speed_actual_word_o)
  );
  dpsp_scale u_current (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .value_i    (current_i),
    .ref_i      (current_reference_i),
    .unsigned_i (1'b1),
    .word_o     (current_actual_word_o)
  );
  dpsp_scale u_torque (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .value_i    (torque_i),
    .ref_i      (torque_reference_i),
    .unsigned_i (1'b0),
    .word_o     (torque_actual_word_o)
  );
  dpsp_scale u_power (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .value_i    (power_i),
    .ref_i      (power_reference_i),
    .unsigned_i (1'b0),
    .word_o     (power_actual_word_o)
  );

  // ****************************************
  // Start-up configuration
  // ****************************************
  // role latched at start-up
  always @(posedge clk_i) begin
    if (rst_i)
      subscr_r <= 1'b0;
    else if (cfg_load_i)
      subscr_r <= cfg_subscriber_i;
  end
  assign subscriber_o = subscr_r;

  // One register set per tap; a new map lands only on a load strobe
  generate
    for (g = 0; g < `DPSP_NUM_TAPS; g = g + 1) begin : g_tap
      reg [6:0] src_r;
      reg [2:0] from_r;
      reg [2:0] to_r;
      reg       en_r;
      always @(posedge clk_i) begin
        if (rst_i) begin
          src_r  <= 7'h00;
          from_r <= 3'h0;
          to_r   <= 3'h0;
          en_r   <= 1'b0;
        end else if (cfg_load_i) begin
          src_r  <= cfg_tap_src_i[g*7 +: 7];
          from_r <= cfg_tap_from_i[g*3 +: 3];
          to_r   <= cfg_tap_to_i[g*3 +: 3];
          en_r   <= cfg_tap_en_i[g];
        end
      end
      assign tap_src_w[g*7 +: 7]  = src_r;
      assign tap_from_w[g*3 +: 3] = from_r;
      assign tap_to_w[g*3 +: 3]   = to_r;
      assign tap_en_w[g]          = en_r;
    end
  endgenerate

  // ****************************************
  // Poll response
  // ****************************************
  reg         resp_vld_nxt;
  reg         resp_bcast_nxt;
  reg  [63:0] resp_data_nxt;
  // Words registered before the poll edge, so all four share one instant
  always @* begin
    resp_vld_nxt   = poll_i;
    resp_bcast_nxt = 1'b0;
    resp_data_nxt  = resp_data_o;
    if (poll_i) begin
      resp_bcast_nxt = fc_is_bcast(poll_fc_i);
      resp_data_nxt  = pack_resp(status_word_o, speed_actual_word_o,
                                 torque_actual_word_o, power_actual_word_o);
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      resp_vld_o   <= 1'b0;
      resp_bcast_o <= 1'b0;
      resp_data_o  <= 64'h0;
    end else begin
      resp_vld_o   <= resp_vld_nxt;
      resp_bcast_o <= resp_bcast_nxt;
      resp_data_o  <= resp_data_nxt;
    end
  end

  // ****************************************
  // Setpoint merge
  // ****************************************
  // Taps overlay master words; higher tap wins a shared slot
  // setpoint merge
  dpsp_tap_merge u_merge (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .subscriber_i    (subscr_r),
    .master_sp_i     (master_sp_i),
    .master_sp_vld_i (poll_i),
    .bcast_data_i    (bcast_data_i),
    .bcast_src_i     (bcast_src_i),
    .bcast_vld_i     (bcast_vld_i),
    .tap_src_i       (tap_src_w),
    .tap_from_i      (tap_from_w),
    .tap_to_i        (tap_to_w),
    .tap_en_i        (tap_en_w),
    .setpoint_o      (setpoint_o)
  );
endmodule // dpsp_packer

// ==== verif/dpsp_packer_chk.sv ====
// Port assertions for the status packer
`timescale 1ns/10ps
`include "dpsp_consts.vh"
module dpsp_packer_chk (
  input wire               clk_i,
  input wire               rst_i,
  input wire [9:0]         telegram_structure_select_i,
  input wire               limit_reached_i,
  input wire               brake_released_i,
  input wire               cds_sel0_i,
  input wire               fault_active_i,
  input wire signed [31:0] speed_i,
  input wire [15:0]        fault_oldest_i,
  input wire               poll_i,
  input wire [3:0]         poll_fc_i,
  input wire [15:0]        status_word_o,
  input wire [15:0]        fault_code_o,
  input wire               resp_vld_o,
  input wire               resp_bcast_o
);
  // ****************
  // Status and poll
  // ****************
  wire std_w = telegram_structure_select_i == `DPSP_TEL_STD1 ||
               telegram_structure_select_i == `DPSP_TEL_STD352;
  wire s20_w = telegram_structure_select_i == `DPSP_TEL_STD20;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_poll(fc); poll_i && poll_fc_i == fc; endsequence
  sequence s_resp(b); resp_vld_o && resp_bcast_o == b; endsequence
  property p_data; s_poll(4'h0) |=> s_resp(1'b0); endproperty
  a_data: assert property (p_data) else $error("data poll answer");
  property p_bc; s_poll(4'h1) |=> s_resp(1'b1); endproperty
  a_bc: assert property (p_bc) else $error("broadcast answer");
  property p_lim; std_w |=> status_word_o[11] == !$past(limit_reached_i); endproperty
  a_lim: assert property (p_lim) else $error("limit bit");
  property p_brk; std_w |=> status_word_o[12] == $past(brake_released_i); endproperty
  a_brk: assert property (p_brk) else $error("brake bit");
  property p_s20; s20_w |=> !status_word_o[12] && status_word_o[15] == $past(cds_sel0_i);
  endproperty
  a_s20: assert property (p_s20) else $error("data set bit");
  property p_r13; !status_word_o[13]; endproperty
  a_r13: assert property (p_r13) else $error("reserved bit");
  property p_fwd; 1'b1 |=> status_word_o[14] == !$past(speed_i[31]); endproperty
  a_fwd: assert property (p_fwd) else $error("direction bit");
  property p_flt; 1'b1 |=> status_word_o[3] == $past(fault_active_i); endproperty
  a_flt: assert property (p_flt) else $error("fault bit");
  property p_fc; 1'b1 |=> fault_code_o == $past(fault_oldest_i); endproperty
  a_fc: assert property (p_fc) else $error("fault code");
endmodule // dpsp_packer_chk
bind dpsp_packer dpsp_packer_chk u_chk (.*);

// ==== verif/dpsp_master_model.sv ====
// Bus master and publisher model
`timescale 1ns/10ps
module dpsp_master_model (
  input  wire         clk_i,
  output reg          poll_o = 1'b0,
  output reg  [3:0]   fc_o = 4'h0,
  output reg  [127:0] sp_o = 128'h0,
  output reg  [127:0] bc_data_o = 128'h0,
  output reg  [6:0]   bc_src_o = 7'h0,
  output reg          bc_vld_o = 1'b0
);
  task poll(input [3:0] fc, input [127:0] sp);
    begin
      fc_o = fc;
      sp_o = sp;
      poll_o = 1'b1;
      @(posedge clk_i);
      #1;
      poll_o = 1'b0;
      // Released lines show garbage, not the last value
      sp_o = ~sp;
      fc_o = ~fc;
    end
  endtask
  task bcast(input [6:0] src, input [127:0] d);
    begin
      bc_src_o = src;
      bc_data_o = d;
      bc_vld_o = 1'b1;
      @(posedge clk_i);
      #1;
      bc_vld_o = 1'b0;
      bc_src_o = ~src;
      bc_data_o = ~d;
    end
  endtask
endmodule // dpsp_master_model

// ==== verif/test_dpsp_packer.sv ====
// Self-checking bench for the status packer
`timescale 1ns/10ps
`include "dpsp_consts.vh"
module test_dpsp_packer;
  reg clk_i = 1'b0, rst_i = 1'b1, cfg_load_i = 1'b0, cfg_subscriber_i = 1'b0;
  reg limit_reached_i = 1'b0, limit_reached_alt_i = 1'b0, brake_released_i = 1'b0;
  reg cds_sel0_i = 1'b0, fault_active_i = 1'b0;
  reg         [9:0]   telegram_structure_select_i = 10'h001;
  reg  signed [31:0]  speed_i = 0, current_i = 0, torque_i = 0, power_i = 0;
  reg         [31:0]  speed_reference_i = 32'h3E8, current_reference_i = 32'h3E8;
  reg         [31:0]  torque_reference_i = 32'h3E8, power_reference_i = 32'h3E8;
  reg         [15:0]  alarm_current_i = 16'h0, alarm_last_i = 16'h0, fault_oldest_i = 16'h0;
  reg         [27:0]  cfg_tap_src_i = 28'h0;
  reg         [11:0]  cfg_tap_from_i = 12'h0, cfg_tap_to_i = 12'h0;
  reg         [3:0]   cfg_tap_en_i = 4'h0;
  reg         [127:0] ex, sp = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
  reg         [127:0] bd = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
  wire [15:0]  status_word_o, speed_actual_word_o, current_actual_word_o, torque_actual_word_o;
  wire [15:0]  power_actual_word_o, alarm_code_cur_o, alarm_code_last_o, fault_code_o;
  wire         resp_vld_o, resp_bcast_o, poll_i, bcast_vld_i, subscriber_o;
  wire [3:0]   poll_fc_i;
  wire [6:0]   bcast_src_i;
  wire [63:0]  resp_data_o;
  wire [127:0] setpoint_o, master_sp_i, bcast_data_i;
  integer err_total = 0, total_checks = 0, cyc = 0, i, k, x, q;
  dpsp_master_model u_mst (.clk_i(clk_i), .poll_o(poll_i), .fc_o(poll_fc_i), .sp_o(master_sp_i),
    .bc_data_o(bcast_data_i), .bc_src_o(bcast_src_i), .bc_vld_o(bcast_vld_i));
  dpsp_packer DUT (.*);
  always #5 clk_i = ~clk_i;
  // ****************
  // Helper tasks
  // ****************
  task chk(input [127:0] s, input [127:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Hang guard, tests need about 66 cycles
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 600) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    step;
    for (i = 0; i < 24; i = i + 1) begin
      k = i * 7;
      telegram_structure_select_i = (i % 3 == 0) ? `DPSP_TEL_STD1 :
                                    (i % 3 == 1) ? `DPSP_TEL_STD352 : `DPSP_TEL_STD20;
      {fault_active_i, cds_sel0_i, brake_released_i, limit_reached_alt_i, limit_reached_i} = k;
      speed_i = k[5] ? -7 : 7;
      step;
      ex = 128'h0;
      ex[3] = fault_active_i;
      ex[14] = !k[5];
      ex[11] = (i % 3 == 2) ? !limit_reached_alt_i : !limit_reached_i;
      ex[12] = (i % 3 != 2) & brake_released_i;
      ex[15] = (i % 3 == 2) & cds_sel0_i;
      chk(status_word_o, ex);
    end
    $display("test status done");
    // Steps of half the reference, both saturation edges included
    for (i = -4; i < 5; i = i + 1) begin
      x = i * 500;
      {speed_i, current_i, torque_i, power_i} = {x, x, x, x};
      step;
      q = x * 16384 / 1000;
      ex = q > 32767 ? 16'h7FFF : q < -32767 ? 16'h8001 : q[15:0];
      chk(speed_actual_word_o, ex);
      chk(torque_actual_word_o, ex);
      chk(power_actual_word_o, ex);
      chk(current_actual_word_o, x < 0 ? 128'h0 : ex);
    end
    $display("test scaling done");
    {alarm_current_i, alarm_last_i, fault_oldest_i} = {16'h1EE6, 16'h0BB8, 16'h1EB4};
    telegram_structure_select_i = `DPSP_TEL_STD1;
    {fault_active_i, cds_sel0_i, brake_released_i, limit_reached_alt_i, limit_reached_i} = 5'h04;
    {speed_i, torque_i, power_i} = {32'sd500, -32'sd500, 32'sd1000};
    step;
    chk({alarm_code_cur_o, alarm_code_last_o}, 32'h1EE6_0BB8);
    chk(fault_code_o, 16'h1EB4);
    u_mst.poll(4'h0, sp);
    chk({resp_vld_o, resp_bcast_o}, 2'b10);
    chk(resp_data_o, 64'h4000_E000_2000_5800);
    chk(setpoint_o, sp);
    step;
    u_mst.poll(4'h1, sp);
    chk({resp_vld_o, resp_bcast_o}, 2'b11);
    $display("test poll done");
    // Two taps on one link, unrelated words
    {cfg_subscriber_i, cfg_tap_src_i} = {1'b1, 28'h0000285};
    {cfg_tap_from_i, cfg_tap_to_i} = {12'h02A, 12'h031};
    cfg_tap_en_i = 4'h3;
    cfg_load_i = 1'b1;
    step;
    cfg_load_i = 1'b0;
    step;
    chk(subscriber_o, 1'b1);
    u_mst.bcast(7'h05, bd);
    ex = sp;
    ex[31:16] = bd[47:32];
    ex[111:96] = bd[95:80];
    chk(setpoint_o, ex);
    step;
    u_mst.bcast(7'h06, ~bd);
    chk(setpoint_o, ex);
    cfg_subscriber_i = 1'b0;
    cfg_load_i = 1'b1;
    step;
    cfg_load_i = 1'b0;
    step;
    u_mst.bcast(7'h05, ~bd);
    chk(setpoint_o, ex);
    $display("test subscriber done");
    finish_test;
  end
endmodule // test_dpsp_packer
